// [hw/rebl_defs.svh]
// constants for the recoverable error bank logger
`ifndef REBL_DEFS_SVH
`define REBL_DEFS_SVH
`define REBL_A_STATUS   12'h000
`define REBL_A_EXTRA    12'h004
`define REBL_A_LOC      12'h008
`define REBL_A_CAP      12'h00c
`define REBL_A_FEAT     12'h010
`define REBL_A_INJ      12'h014
`define REBL_A_LAST     12'h018
`define REBL_B_LIVE     6'd63
`define REBL_B_OVER     6'd62
`define REBL_B_UC       6'd61
`define REBL_B_EN       6'd60
`define REBL_B_EXTRA_INFO_PRESENT    6'd59
`define REBL_B_LOCATION_PRESENT    6'd58
`define REBL_B_PCC      6'd57
`define REBL_B_SIG      6'd56
`define REBL_B_AR       6'd55
`define REBL_B_CAP_SER  5'd24
`define REBL_B_FEAT_ARCH 5'd14
`define REBL_B_FEAT_EXC  5'd7
`define REBL_CAP_RST    32'h0100_0000
`define REBL_FEAT_VAL   32'h0000_4080
`endif

// [hw/rebl_pkg.sv]
// types for the recoverable error bank logger
package rebl_pkg;
  typedef enum logic [2:0] {
    REBL_CE  = 3'b000,
    REBL_SILENT_RECOVERABLE_CLASS = 3'b001,
    REBL_OPT = 3'b010,
    REBL_MAN = 3'b011,
    REBL_UC  = 3'b100
  } rebl_class_type;
  typedef struct packed {
    logic        valid;
    logic        uncorrected;
    logic        consumed;
    logic        via_exception;
    logic        extra_ok;
    logic        loc_ok;
    logic [15:0] code;
    logic [31:0] extra;
    logic [31:0] loc;
  } rebl_err_type;
endpackage

// [hw/rebl_classify.sv]
// sorts one error report into a class and its signalling path
`timescale 1ns/1ps
`include "rebl_defs.svh"
module rebl_classify
  import rebl_pkg::*;
(
  input  wire rebl_pkg::rebl_err_type  err,
  input  wire logic                    ser_cap,
  output rebl_pkg::rebl_class_type     cls
);
  // recoverable classes need the capability bit, else an uncorrected is fatal
  wire logic corrupt = err.uncorrected & !ser_cap; // [RL12]
  assign cls = !err.uncorrected ? REBL_CE :
               corrupt          ? REBL_UC :
               err.consumed     ? REBL_MAN : // [RL8]
               err.via_exception ? REBL_OPT : REBL_SILENT_RECOVERABLE_CLASS;
endmodule

// [hw/rebl_logger.sv]
// one error bank: classification, overwrite rules and apb register access
// How it works
// RL1: recoverable entry has live 63, uncorrected 61 set, context-corrupt 57 clear.
// RL2: signal-raised bit 56 set only when an exception was raised.
// RL3: action-needed bit 55 marks mandatory recovery before more work.
// RL4: silent recoverable: flags clear, reported by corrected interrupt only.
// RL5: optional recovery by exception: signal-raised and enable set.
// RL6: optional recovery by interrupt: signal-raised clear.
// RL7: mandatory recovery: signal, enable, action set; always an exception.
// RL8: mandatory only when raised where corrupt data is consumed.
// RL9: extra-info and location flags set only with valid supplementary data.
// RL10: non-recoverable: uncorrected, enable, context-corrupt set; exception.
// RL11: corrected error: uncorrected clear, corrected interrupt only.
// RL12: recoverable classes exist only with recovery capability bit 24.
// RL13: recoverable error replaces a logged corrected error.
// RL14: context-corrupting error replaces recoverable, never the reverse.
// RL15: second recoverable error keeps the first entry.
// RL16: corrected error does not touch a logged recoverable entry.
// RL17: any second error sets overflow.
// RL18: signal-raised and action-needed are sticky over second errors.
// RL19: other information may take the second error's details.
// RL20: handler resets after overflow only with action or corrupt set.
// RL21: handler recovers mandatory errors before scheduling more work.
// RL22: handler should shut down when mandatory lacks supplementary flags.
// RL23: handler skips recovery of optional error lacking supplementary flags.
// RL24: feature flags advertise check architecture bit 14, exception bit 7.
// RL25: second corrected error keeps bank live and sets overflow.
`timescale 1ns/1ps
`include "rebl_defs.svh"
module rebl_logger
  import rebl_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   arst_n,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire rebl_pkg::rebl_err_type err_in,
  output logic                        check_exception,
  output logic                        corrected_error_interrupt
);
  import rebl_pkg::*;

  logic [63:0]  status_r;
  logic [63:0]  status_nxt;
  logic [31:0]  extra_r;
  logic [31:0]  loc_r;
  logic [31:0]  cap_r;
  logic [31:0]  prdata_r;
  logic         pready_r;
  logic         pslverr_r;
  logic         exc_r;
  logic         cei_r;
  logic [2:0]   last_r;
  rebl_class_type cls;
  rebl_err_type   inj_r;

  // an error comes either from the pin group or from a software injection
  wire rebl_err_type err = err_in.valid ? err_in : inj_r;

  rebl_classify u_cls (
    .err     (err),
    .ser_cap (cap_r[`REBL_B_CAP_SER]),
    .cls     (cls)
  );

  wire logic acc    = psel & penable & pready_r;
  wire logic wr     = acc & pwrite;
  wire logic setup  = psel & !penable;
  wire logic hit_st = paddr == `REBL_A_STATUS;
  wire logic hit_ex = paddr == `REBL_A_EXTRA;
  wire logic hit_lc = paddr == `REBL_A_LOC;
  wire logic hit_cp = paddr == `REBL_A_CAP;
  wire logic hit_ft = paddr == `REBL_A_FEAT;
  wire logic hit_ij = paddr == `REBL_A_INJ;
  wire logic hit_ls = paddr == `REBL_A_LAST;
  wire logic mapped = hit_st | hit_ex | hit_lc | hit_cp | hit_ft |
                      hit_ij | hit_ls;

  // class flags of a fresh entry
  wire logic n_uc   = cls != REBL_CE; // [RL11]
  wire logic n_pcc  = cls == REBL_UC; // [RL1] [RL10]
  wire logic n_sig  = (cls == REBL_OPT) | (cls == REBL_MAN); // [RL2] [RL4] [RL5] [RL6]
  wire logic n_ar   = cls == REBL_MAN; // [RL3] [RL7]
  wire logic n_en   = n_sig | n_pcc; // [RL5] [RL7] [RL10]
  wire logic n_exc  = n_sig | n_pcc; // [RL4] [RL7] [RL10] [RL11]

  wire logic live   = status_r[`REBL_B_LIVE];
  wire logic o_uc   = status_r[`REBL_B_UC];
  wire logic o_pcc  = status_r[`REBL_B_PCC];
  wire logic o_ucr  = live & o_uc & !o_pcc;
  wire logic o_ce   = live & !o_uc;
  wire logic n_ucr  = n_uc & !n_pcc;

  // which entry the bank keeps after a second error
  wire logic replace = !live | (o_ce & n_uc) | // [RL13]
                       (o_ucr & n_pcc) | // [RL14]
                       (o_ce & !n_uc); // [RL19] [RL25]
  // a recoverable arriving on a corrupting entry, or on another recoverable,
  // or a corrected one on a recoverable, leaves the first entry alone
  wire logic keep   = !replace; // [RL14] [RL15] [RL16]

  wire logic [63:0] fresh = {1'b1, live, n_uc, n_en,
                             err.extra_ok, err.loc_ok, // [RL9]
                             n_pcc, n_sig, n_ar, 39'h0, err.code};

  always_comb begin
    status_nxt = status_r;
    // an error in the same cycle wins over a software status write
    if (wr && hit_st && !err.valid)
      status_nxt = {pwdata, pwdata};
    if (err.valid) begin
      if (replace)
        status_nxt = fresh; // [RL19]
      status_nxt[`REBL_B_OVER] = live; // [RL17]
      // sticky across the second error
      if (live) begin
        status_nxt[`REBL_B_SIG] = status_r[`REBL_B_SIG] |
                                   (n_ucr & n_sig) |
                                   (replace & n_sig); // [RL18]
        status_nxt[`REBL_B_AR]  = status_r[`REBL_B_AR] |
                                   (n_ucr & n_ar) |
                                   (replace & n_ar); // [RL18]
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      status_r <= 64'h0;
      extra_r  <= 32'h0;
      loc_r    <= 32'h0;
    end else begin
      status_r <= status_nxt;
      // supplementary data only follows an entry that is taken
      if (err.valid && replace && err.extra_ok)
        extra_r <= err.extra; // [RL9]
      else if (wr && hit_ex)
        extra_r <= pwdata;
      if (err.valid && replace && err.loc_ok)
        loc_r <= err.loc; // [RL9]
      else if (wr && hit_lc)
        loc_r <= pwdata;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cap_r <= `REBL_CAP_RST;
      inj_r <= '0;
    end else begin
      if (wr && hit_cp)
        cap_r <= pwdata;
      // injection is a one-cycle event that the pin group overrides
      inj_r       <= '0;
      inj_r.valid <= wr & hit_ij;
      inj_r.uncorrected   <= pwdata[0];
      inj_r.consumed      <= pwdata[1];
      inj_r.via_exception <= pwdata[2];
      inj_r.code          <= pwdata[31:16];
    end
  end

  // status word halves: high half read at +0, low code bits 15:0 read at +0x18 with the last class
  wire logic [31:0] rd_val =
    hit_st ? status_r[63:32] :
    hit_ex ? extra_r :
    hit_lc ? loc_r :
    hit_cp ? cap_r :
    hit_ft ? `REBL_FEAT_VAL : // [RL24]
    hit_ls ? {13'h0, last_r, status_r[15:0]} : 32'h0;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_r  <= 32'h0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      exc_r     <= 1'b0;
      cei_r     <= 1'b0;
      last_r    <= 3'h0;
    end else begin
      // no wait state: answer in the cycle after setup
      pready_r  <= setup;
      pslverr_r <= setup & !mapped;
      prdata_r  <= (setup & !pwrite) ? rd_val : 32'h0;
      exc_r     <= err.valid & n_exc; // [RL7] [RL10]
      cei_r     <= err.valid & !n_exc; // [RL4] [RL6] [RL11]
      if (err.valid)
        last_r <= cls;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign check_exception           = exc_r;
  assign corrected_error_interrupt = cei_r;

  a_sticky_sig: assert property (@(posedge mclk) disable iff (!arst_n)
    status_r[`REBL_B_SIG] && !(wr && hit_st) |=> status_r[`REBL_B_SIG])
    else $error("signal flag cleared by error"); // [RL18]
  a_sticky_ar: assert property (@(posedge mclk) disable iff (!arst_n)
    status_r[`REBL_B_AR] && !(wr && hit_st) |=> status_r[`REBL_B_AR])
    else $error("action flag cleared by error"); // [RL18]
  a_over_set: assert property (@(posedge mclk) disable iff (!arst_n)
    err.valid && live |=> status_r[`REBL_B_OVER] && status_r[`REBL_B_LIVE])
    else $error("overflow not set"); // [RL17] [RL25]
  a_man_exc: assert property (@(posedge mclk) disable iff (!arst_n)
    err.valid && cls == REBL_MAN |=> check_exception
      && !corrected_error_interrupt)
    else $error("mandatory not raised as exception"); // [RL7]
  a_silent_cei: assert property (@(posedge mclk) disable iff (!arst_n)
    err.valid && cls == REBL_SILENT_RECOVERABLE_CLASS |=> corrected_error_interrupt
      && !check_exception)
    else $error("silent error on wrong path"); // [RL4]
  a_ce_path: assert property (@(posedge mclk) disable iff (!arst_n)
    err.valid && !err.uncorrected |=> !check_exception)
    else $error("corrected error raised exception"); // [RL11]
  a_nocap_ucr: assert property (@(posedge mclk) disable iff (!arst_n)
    err.valid && err.uncorrected && !cap_r[`REBL_B_CAP_SER] && !live
      |=> status_r[`REBL_B_PCC])
    else $error("recoverable class without capability"); // [RL12]
  a_ucr_fresh: assert property (@(posedge mclk) disable iff (!arst_n)
    err.valid && !live && n_ucr |=> status_r[`REBL_B_UC]
      && !status_r[`REBL_B_PCC] && status_r[`REBL_B_LIVE])
    else $error("recoverable entry flags wrong"); // [RL1]
  a_keep_first: assert property (@(posedge mclk) disable iff (!arst_n)
    err.valid && o_ucr && !n_pcc |=> status_r[15:0] == $past(status_r[15:0]))
    else $error("first recoverable entry lost"); // [RL15] [RL16]
  a_pcc_wins: assert property (@(posedge mclk) disable iff (!arst_n)
    err.valid && live && (o_pcc || n_pcc) |=> status_r[`REBL_B_PCC]
      && status_r[`REBL_B_UC])
    else $error("context corrupt entry lost"); // [RL14]

  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // a read setup cycle, answered in the next cycle
  sequence s_rd_setup;
    psel && !penable && !pwrite;
  endsequence
  // an error taken into a bank that holds nothing yet
  sequence s_err_fresh;
    err.valid && !live;
  endsequence
  // an error taken on a recoverable entry
  sequence s_err_on_ucr;
    err.valid && o_ucr;
  endsequence
  // status and capability flags as the assertions see them
  wire logic        f_over = status_r[`REBL_B_OVER];
  wire logic        f_en   = status_r[`REBL_B_EN];
  wire logic        f_sig  = status_r[`REBL_B_SIG];
  wire logic        f_ar   = status_r[`REBL_B_AR];
  wire logic        f_mv   = status_r[`REBL_B_EXTRA_INFO_PRESENT];
  wire logic        f_av   = status_r[`REBL_B_LOCATION_PRESENT];
  wire logic [15:0] f_code = status_r[15:0];
  wire logic        f_ser  = cap_r[`REBL_B_CAP_SER];
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_quiet: assert property (!err.valid |=> !check_exception
    && !corrected_error_interrupt)
    else $error("path pulse without error");
  a_one_path: assert property (err.valid |=> // [RL4] [RL11]
    check_exception != corrected_error_interrupt)
    else $error("error raised on no path or both");
  a_opt_exc: assert property (err.valid && cls == REBL_OPT |=> // [RL5]
    check_exception)
    else $error("optional error not raised");
  a_opt_cei: assert property (err.valid && cls != REBL_UC && // [RL6]
    err.uncorrected && !err.via_exception && !err.consumed |=>
    corrected_error_interrupt && !check_exception)
    else $error("interrupt path error raised as exception");
  a_uc_exc: assert property (err.valid && cls == REBL_UC |=> // [RL10]
    check_exception)
    else $error("corrupting error not raised");
  a_fresh_man: assert property (s_err_fresh ##0 cls == REBL_MAN |=> // [RL7]
    o_uc && !o_pcc && f_sig && f_en && f_ar)
    else $error("mandatory entry flags wrong");
  a_fresh_opt: assert property (s_err_fresh ##0 cls == REBL_OPT |=> // [RL5]
    o_uc && !o_pcc && f_sig && f_en && !f_ar)
    else $error("optional entry flags wrong");
  a_fresh_sil: assert property (s_err_fresh ##0 cls == REBL_SILENT_RECOVERABLE_CLASS |=> // [RL4]
    o_uc && !o_pcc && !f_sig && !f_ar)
    else $error("silent entry flags wrong");
  a_fresh_uc: assert property (s_err_fresh ##0 cls == REBL_UC |=> // [RL10]
    o_uc && o_pcc && f_en)
    else $error("corrupting entry flags wrong");
  a_fresh_ce: assert property (s_err_fresh ##0 cls == REBL_CE |=> // [RL11]
    live && !o_uc && !f_over)
    else $error("corrected entry flags wrong");
  a_fresh_supp: assert property (s_err_fresh |=> // [RL9]
    f_mv == $past(err.extra_ok) && f_av == $past(err.loc_ok))
    else $error("supplementary flags wrong");
  a_ce_replaced: assert property (err.valid && o_ce && n_uc |=> // [RL13]
    f_code == $past(err.code) && o_uc)
    else $error("recoverable did not replace corrected");
  a_ce_kept: assert property (s_err_on_ucr ##0 cls == REBL_CE |=> // [RL16]
    f_code == $past(f_code) && o_uc && !o_pcc)
    else $error("corrected error touched recoverable entry");
  a_ucr_lost: assert property (s_err_on_ucr ##0 n_pcc |=> // [RL14]
    f_code == $past(err.code))
    else $error("corrupting error did not replace");
  a_pcc_first: assert property (err.valid && live && o_pcc |=> // [RL14]
    f_code == $past(f_code))
    else $error("corrupting entry overwritten");
  a_ar_merge: assert property (s_err_on_ucr ##0 cls == REBL_MAN |=> // [RL18]
    f_ar && f_sig)
    else $error("action flag not merged");
  a_sig_merge: assert property (s_err_on_ucr ##0 cls == REBL_OPT |=> // [RL18]
    f_sig)
    else $error("signal flag not merged");
  a_silent_pair: assert property (s_err_on_ucr ##0 !f_sig // [RL18]
    && cls == REBL_SILENT_RECOVERABLE_CLASS |=> !f_sig)
    else $error("two silent errors raised signal flag");
  a_ce_pair: assert property (err.valid && o_ce && cls == REBL_CE |=> // [RL25]
    live && f_over && !o_uc)
    else $error("second corrected error lost bank");
  a_over_fresh: assert property (s_err_fresh |=> !f_over) // [RL17]
    else $error("overflow set on empty bank");
  a_nocap_cls: assert property (err.valid && !f_ser |-> // [RL12]
    cls == REBL_CE || cls == REBL_UC)
    else $error("recoverable class without capability");
  a_man_use: assert property (err.valid && cls == REBL_MAN |-> // [RL8]
    err.consumed)
    else $error("mandatory class without consumption");
  a_xload: assert property (err.valid && replace && err.extra_ok |=> // [RL9]
    extra_r == $past(err.extra))
    else $error("extra info not loaded");
  a_lload: assert property (err.valid && replace && err.loc_ok |=> // [RL9]
    loc_r == $past(err.loc))
    else $error("fault location not loaded");
  a_xhold: assert property (err.valid && !replace // [RL15]
    && !(wr && hit_ex) |=> $stable(extra_r))
    else $error("kept entry lost its extra info");
  a_feat_rd: assert property (s_rd_setup ##0 hit_ft |=> // [RL24]
    prdata == `REBL_FEAT_VAL)
    else $error("feature flags read wrong");
  a_unmapped: assert property (psel && !penable && !mapped |=>
    pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_last_cls: assert property (err.valid |=> last_r == $past(cls))
    else $error("last class not recorded");
  a_wr_lands: assert property (wr && hit_cp |=> cap_r == $past(pwdata))
    else $error("capability write lost");
  a_clr_bank: assert property (wr && hit_st && !err.valid |=>
    status_r == {$past(pwdata), $past(pwdata)})
    else $error("status write lost");
  a_inj_take: assert property (wr && hit_ij |=> inj_r.valid)
    else $error("injection not taken");
endmodule

// [dv/rebl_handler.sv]
// handler model: recovery decisions drawn from a bank status word
`timescale 1ns/1ps
module rebl_handler (
  input  wire logic [31:0] st_hi,
  output logic             need_reset,
  output logic             shut_down,
  output logic             skip_recovery
);
  wire no_data = ~(st_hi[27] & st_hi[26]);
  // corrupt context, or overflow over a mandatory entry
  assign need_reset = st_hi[31] & st_hi[29]
                    & (st_hi[25] | st_hi[30] & st_hi[23]);
  // mandatory entry lacking extra info or location data cannot be repaired
  assign shut_down = st_hi[31] & st_hi[23] & no_data;
  // optional entry lacking extra info or location data: resume, no repair
  assign skip_recovery = st_hi[24] & ~st_hi[23] & no_data;
endmodule

// [dv/tb_rebl_logger.sv]
// self-checking bench for the recoverable error bank logger
`timescale 1ns/1ps
`include "rebl_defs.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_rebl_logger;
  import rebl_pkg::*;
  logic         mclk = 0;
  logic         arst_n = 0;
  logic         psel = 0;
  logic         penable = 0;
  logic         pwrite = 0;
  logic [11:0]  paddr = '0;
  logic [31:0]  pwdata = '0;
  logic [31:0]  prdata, rd, sh, e, mk;
  logic         pready, pslverr, se, exc, cmi, need_rst, shut, skip;
  logic [31:0]  xv, lv;
  logic [31:0]  m_x = '0;
  logic [31:0]  m_l = '0;
  rebl_err_type err_in = '0;
  int           n_errors = 0;
  int           checks = 0;
  int           cyc = 0;
  int           seed = 98563;
  int           m_live, m_over, m_cls, m_sig, m_ar, m_mv, m_av;
  logic [15:0]  m_code;
  always #12.5 mclk = ~mclk;
  rebl_logger dut (.mclk(mclk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .err_in(err_in),
    .check_exception(exc), .corrected_error_interrupt(cmi));
  rebl_handler handler (.st_hi(sh), .need_reset(need_rst),
    .shut_down(shut), .skip_recovery(skip));
  task automatic give_verdict;
    if (n_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // a hung handshake ends here rather than stalling the run
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      give_verdict;
    end
  end
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic clr;
    apb(1'b1, `REBL_A_STATUS, 32'h0);
    {m_live, m_over, m_sig, m_ar} = '0;
  endtask
  // c: 0 corrected, 1 silent, 2 optional, 3 mandatory, 4 corrupt
  task automatic inj(input int c, input logic [15:0] cd,
                     input logic xo, input logic lo);
    // corrupt errors are made by dropping recovery support
    if (c == 4) apb(1'b1, `REBL_A_CAP, 32'h0);
    xv = $random(seed);
    lv = $random(seed);
    @(posedge mclk);
    err_in <= '{valid: 1'b1, uncorrected: c != 0, consumed: c >= 3,
      via_exception: c >= 2, extra_ok: xo, loc_ok: lo, code: cd,
      extra: xv, loc: lv};
    @(posedge mclk);
    err_in.valid <= 1'b0;
    #1;
    `CHK("exception", c >= 2, exc)
    `CHK("interrupt", c < 2, cmi)
    if (c == 4) apb(1'b1, `REBL_A_CAP, `REBL_CAP_RST);
    if (!m_live || m_cls == 0 || (c == 4 && m_cls != 4)) begin
      m_cls  = c;
      m_code = cd;
      m_mv   = xo;
      m_av   = lo;
      if (xo) m_x = xv;
      if (lo) m_l = lv;
    end
    m_over = m_live;
    m_live = 1;
    m_sig |= (c == 2 || c == 3);
    m_ar  |= (c == 3);
    e  = {2'b11, m_cls != 0, 1'b1, m_mv[0], m_av[0], m_cls == 4,
          m_sig[0], m_ar[0], 23'h0};
    mk = {3'b111, m_cls >= 2 && m_over == 0, 2'b11, m_cls != 0,
          {2{m_cls inside {[1:3]}}}, 23'h0};
    e[30] = m_over[0];
    apb(1'b0, `REBL_A_STATUS, 32'h0);
    sh = rd;
    `CHK("status", e & mk, rd & mk)
    apb(1'b0, `REBL_A_LAST, 32'h0);
    `CHK("code", m_code, rd[15:0])
    `CHK("last class", c[2:0], rd[18:16])
    apb(1'b0, `REBL_A_EXTRA, 32'h0);
    `CHK("extra info", m_x, rd)
    apb(1'b0, `REBL_A_LOC, 32'h0);
    `CHK("location", m_l, rd)
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    apb(1'b0, `REBL_A_STATUS, 32'h0);
    `CHK("status reset", 32'h0, rd)
    apb(1'b0, `REBL_A_CAP, 32'h0);
    `CHK("capability", `REBL_CAP_RST, rd)
    apb(1'b0, `REBL_A_FEAT, 32'h0);
    `CHK("features", 2'b11, {rd[14], rd[7]})
    apb(1'b0, 12'h01c, 32'h0);
    `CHK("unmapped", 1'b1, se)
    for (int a = 0; a < 5; a++) begin
      for (int b = 0; b < 5; b++) begin
        if (a == 4 && (b == 0 || b == 4)) continue;
        clr;
        inj(a, 16'($random(seed)), 1'($random(seed)), 1'($random(seed)));
        inj(b, 16'($random(seed)), 1'($random(seed)), 1'($random(seed)));
        #1;
        `CHK("reset", m_cls == 4 || m_ar != 0, need_rst)
        `CHK("shut", m_ar != 0 && !(m_mv && m_av), shut)
        `CHK("skip", m_sig != 0 && m_ar == 0 && !(m_mv && m_av), skip)
      end
    end
    clr;
    // software injection of a mandatory error with code 1234
    apb(1'b1, `REBL_A_INJ, 32'h1234_0007);
    apb(1'b0, `REBL_A_STATUS, 32'h0);
    `CHK("inject", 4'b1011, {rd[29], rd[25:23]})
    apb(1'b0, `REBL_A_LAST, 32'h0);
    `CHK("inject code", 19'h3_1234, rd[18:0])
    give_verdict;
  end
endmodule
